// file: hdl/ctor_readout.sv
// Trigger object search, real-time output, read-out event builder and slow control
//
// Contract
// RULE1: On accept, copy real-time data to read-out
// RULE2: Each unit takes 58 lanes, finds candidates
// RULE3: One record per candidate: type, energy, position
// RULE4: Circular memories record input and output data
// RULE5: Accept moves accepted crossing into derandomiser
// RULE6: Unit packet carries bunch number to interface
// RULE7: One unit merges all records per crossing
// RULE8: Identical output copies to six topological processors
// RULE9: Exactly one merged packet per event to hub; an accept that finds a derandomiser full gets none and sets the lost flag
// RULE10: Timing commands forwarded to all processor units
// RULE11: Read-out interface exposes control and status
// RULE12: Control unit holds module-wide control and status
// RULE13: Switch routes slow-control traffic to right unit
// RULE14: Every unit parameter readable and writable
// RULE15: Loopback forwards lane with about 25 ns
// RULE16: Identical logic, programmable core area limits
// RULE17: Output frame follows input lane format
// RULE18: Monitoring data passed on to hub
// RULE19: Configuration loader writes unit parameters
// RULE20: Wait for all four; flag bunch mismatch
`timescale 1ns/1ps
module ctor_readout #(
  parameter int L1_LAT = ctor_pkg::L1_LATENCY,
  parameter int FIFO_D = ctor_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // Calorimeter lanes, per unit
  input wire logic [ctor_pkg::NUM_UNITS-1:0][ctor_pkg::NUM_LANES-1:0][ctor_pkg::LANE_W-1:0] LANE_DATA,
  output logic [ctor_pkg::NUM_UNITS-1:0][ctor_pkg::LANE_W-1:0] SERDES_LOOP_TX,
  // Timing and trigger control
  input wire logic BUNCH_RESET,
  input wire logic LEVEL1_ACCEPT,
  // Slow control
  input wire logic SC_VALID,
  input wire ctor_pkg::ctor_sc_cmd_t SC_CMD,
  output logic SC_RVALID,
  output logic [ctor_pkg::SC_W-1:0] SC_RDATA,
  // Configuration loader
  input wire logic CFG_VALID,
  input wire ctor_pkg::ctor_sc_cmd_t CFG_CMD,
  // Real-time output to topological processors
  output ctor_pkg::ctor_frame_t [ctor_pkg::NUM_TOPO-1:0] TOPO_FRAME,
  // Read-out to hub
  output logic HUB_VALID,
  input wire logic HUB_READY,
  output ctor_pkg::ctor_event_t HUB_EVENT,
  output logic RO_BUSY,
  // Environment monitoring
  input wire logic MON_VALID,
  input wire logic [ctor_pkg::SC_W-1:0] MON_DATA,
  output logic HUB_MON_VALID,
  output logic [ctor_pkg::SC_W-1:0] HUB_MON_DATA
);
  import ctor_pkg::*;

  // ****************************************************************
  // Checksum over the frame payload
  // ****************************************************************
  function automatic logic [CHECK_W-1:0] frame_check(input logic [PAYLOAD_W-1:0] p);
    logic [CHECK_W-1:0] c;
    c = '0;
    for (int i = 0; i < PAYLOAD_W / CHECK_W; i++) begin
      c = c ^ p[i*CHECK_W +: CHECK_W];
    end
    return c;
  endfunction : frame_check

  // ****************************************************************
  // Timing: bunch counter and accept forwarding
  // ****************************************************************
  logic [BCID_W-1:0] bcid_reg;
  logic accept_reg;
  logic [BCID_W-1:0] acc_bcid_reg;

  // Every unit sees the same bunch count and accept strobe
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      bcid_reg <= '0;
      accept_reg <= 1'b0;
      acc_bcid_reg <= '0;
    end else begin
      bcid_reg <= BUNCH_RESET ? '0 : bcid_reg + BCID_W'(1); // [RULE10]
      accept_reg <= LEVEL1_ACCEPT; // [RULE10]
      acc_bcid_reg <= bcid_reg - BCID_W'(L1_LAT);
    end
  end

  // ****************************************************************
  // Command switch: loader has priority over slow control
  // ****************************************************************
  wire cfg_sel = CFG_VALID;
  wire ctor_sc_cmd_t cmd = cfg_sel ? CFG_CMD : SC_CMD;
  wire cmd_valid = CFG_VALID || SC_VALID;
  wire cmd_wr = cmd_valid && (cfg_sel || cmd.write); // [RULE19]
  wire cmd_rd = SC_VALID && !cfg_sel && !SC_CMD.write;
  wire status_clr = cmd_wr && (cmd.addr == SC_STATUS);

  // ****************************************************************
  // Per-unit processing
  // ****************************************************************
  ctor_rec_t rec_q [NUM_UNITS];
  logic rec_v_q [NUM_UNITS];
  logic [SC_W-1:0] unit_rd [NUM_UNITS];
  ctor_unit_pkt_t unit_pkt [NUM_UNITS];
  logic [NUM_UNITS-1:0] pkt_valid;
  logic [NUM_UNITS-1:0] fifo_in_ready;
  wire push_all = accept_reg && (&fifo_in_ready);
  wire take;

  genvar u;
  generate
    for (u = 0; u < NUM_UNITS; u++) begin : g_unit
      logic [POS_W-1:0] core_lo_reg;
      logic [POS_W-1:0] core_hi_reg;
      logic [ENERGY_W-1:0] thresh_reg;
      logic [ENERGY_W-1:0] best_e;
      logic [POS_W-1:0] best_i;
      ctor_rec_t rec_reg;
      logic rec_v_reg;
      ctor_rec_t ring_rec [RING_D];
      logic ring_v [RING_D];
      logic [BCID_W-1:0] ring_bcid [RING_D];
      logic [LANE_W-1:0] ring_raw [RING_D];
      logic [LANE_W-1:0] lb_pipe_reg [LOOP_CYC];
      wire [RING_AW-1:0] wr_idx = bcid_reg[RING_AW-1:0];
      wire [RING_AW-1:0] rd_idx = acc_bcid_reg[RING_AW-1:0];
      wire [LANE_W-1:0] best_raw = LANE_DATA[u][best_i];
      wire cand = best_e > thresh_reg;
      wire ctor_rec_t rec_next = '{is_tau: best_raw[TAU_BIT], energy: best_e,
                                   eta: best_i, phi: 2'(u)};
      wire sel = cmd_wr && (cmd.unit == 2'(u)); // [RULE13]
      ctor_unit_pkt_t pkt_in;

      // Largest energy inside the programmed core area
      always_comb begin
        best_e = '0;
        best_i = '0;
        for (int i = 0; i < NUM_LANES; i++) begin
          if (POS_W'(i) >= core_lo_reg && POS_W'(i) <= core_hi_reg && // [RULE16]
              LANE_DATA[u][i][ENERGY_W-1:0] > best_e) begin // [RULE2]
            best_e = LANE_DATA[u][i][ENERGY_W-1:0];
            best_i = POS_W'(i);
          end
        end
      end

      // Programmable parameters, identical in every unit
      always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
          core_lo_reg <= CORE_LO_RST;
          core_hi_reg <= CORE_HI_RST;
          thresh_reg <= THRESH_RST;
        end else if (sel) begin
          if (cmd.addr == SC_CORE_LO) core_lo_reg <= cmd.wdata[POS_W-1:0]; // [RULE14]
          if (cmd.addr == SC_CORE_HI) core_hi_reg <= cmd.wdata[POS_W-1:0]; // [RULE14]
          if (cmd.addr == SC_THRESH) thresh_reg <= cmd.wdata[ENERGY_W-1:0]; // [RULE14]
        end
      end

      // One record per candidate per crossing
      always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
          rec_reg <= '0;
          rec_v_reg <= 1'b0;
        end else begin
          rec_reg <= cand ? rec_next : '0; // [RULE3]
          rec_v_reg <= cand; // [RULE3]
        end
      end

      // Circular memories overwrite the oldest crossing each cycle;
      // the accept latency must stay below the ring depth
      always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
          for (int k = 0; k < RING_D; k++) ring_v[k] <= 1'b0;
        end else begin
          ring_v[wr_idx] <= cand; // [RULE4]
        end
      end
      always_ff @(posedge CORE_CLK) begin
        ring_rec[wr_idx] <= rec_next; // [RULE4]
        ring_bcid[wr_idx] <= bcid_reg;
        ring_raw[wr_idx] <= best_raw; // [RULE4]
      end

      // Loopback delay line stands in for the transceiver path
      always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
          for (int k = 0; k < LOOP_CYC; k++) lb_pipe_reg[k] <= '0;
        end else begin
          lb_pipe_reg[0] <= LANE_DATA[u][0]; // [RULE15]
          for (int k = 1; k < LOOP_CYC; k++) lb_pipe_reg[k] <= lb_pipe_reg[k-1];
        end
      end

      // Accepted crossing, tagged with its own bunch number
      always_comb begin
        pkt_in.bcid = ring_bcid[rd_idx]; // [RULE6]
        pkt_in.rec_valid = ring_v[rd_idx];
        pkt_in.rec = ring_rec[rd_idx]; // [RULE1]
        pkt_in.raw = ring_raw[rd_idx];
      end

      // Derandomiser absorbs accept bursts while the hub stalls
      ctor_fifo #(
        .W($bits(ctor_unit_pkt_t)),
        .DEPTH(FIFO_D)
      ) u_derand (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .in_valid(push_all), // [RULE5]
        .in_ready(fifo_in_ready[u]),
        .in_data(pkt_in),
        .out_valid(pkt_valid[u]),
        .out_ready(take),
        .out_data(unit_pkt[u])
      );

      assign rec_q[u] = rec_reg;
      assign rec_v_q[u] = rec_v_reg;
      assign SERDES_LOOP_TX[u] = lb_pipe_reg[LOOP_CYC-1];
      assign unit_rd[u] = (cmd.addr == SC_CORE_LO) ? SC_W'(core_lo_reg) :
                          (cmd.addr == SC_CORE_HI) ? SC_W'(core_hi_reg) :
                          SC_W'(thresh_reg);
    end
  endgenerate

  // ****************************************************************
  // Real-time merge and fan-out
  // ****************************************************************
  logic [PAYLOAD_W-1:0] rt_payload;
  ctor_frame_t [NUM_TOPO-1:0] topo_reg;

  // All unit records of a crossing packed into one lane-format frame
  always_comb begin
    rt_payload = '0;
    for (int k = 0; k < NUM_UNITS; k++) begin
      rt_payload[k*($bits(ctor_rec_t)+1) +: $bits(ctor_rec_t)+1] = {rec_v_q[k], rec_q[k]}; // [RULE7]
    end
  end

  // Every link gets the same frame in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      topo_reg <= '0;
    end else begin
      for (int t = 0; t < NUM_TOPO; t++) begin
        topo_reg[t] <= '{payload: rt_payload, check: frame_check(rt_payload)}; // [RULE8] [RULE17]
      end
    end
  end
  assign TOPO_FRAME = topo_reg;

  // ****************************************************************
  // Event builder toward the hub
  // ****************************************************************
  logic hub_valid_reg;
  ctor_event_t hub_event_reg;
  logic [NUM_UNITS-1:0] bc_diff;
  logic busy_reg;
  logic mismatch_reg;
  logic lost_reg;
  ctor_event_t ev_next;

  // Build only once every unit has its packet for the event
  assign take = (&pkt_valid) && (!hub_valid_reg || HUB_READY); // [RULE20]

  // Bunch numbers are compared against the first unit
  always_comb begin
    for (int k = 0; k < NUM_UNITS; k++) begin
      bc_diff[k] = unit_pkt[k].bcid != unit_pkt[0].bcid;
      ev_next.units[k] = unit_pkt[k];
    end
    ev_next.mismatch = |bc_diff; // [RULE20]
  end

  // One merged packet per buffered event, held until the hub takes it
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      hub_valid_reg <= 1'b0;
      hub_event_reg <= '0;
    end else begin
      if (take) hub_event_reg <= ev_next; // [RULE9]
      hub_valid_reg <= take || (hub_valid_reg && !HUB_READY); // [RULE9]
    end
  end
  assign HUB_VALID = hub_valid_reg;
  assign HUB_EVENT = hub_event_reg;

  // Busy follows the buffers; mismatch and lost are sticky, a new event wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      busy_reg <= 1'b0;
      mismatch_reg <= 1'b0;
      lost_reg <= 1'b0;
    end else begin
      busy_reg <= ~(&fifo_in_ready); // [RULE11]
      mismatch_reg <= (take && ev_next.mismatch) || (mismatch_reg && !status_clr); // [RULE20]
      lost_reg <= (accept_reg && !push_all) || (lost_reg && !status_clr); // [RULE11]
    end
  end
  assign RO_BUSY = busy_reg;

  // ****************************************************************
  // Slow-control read-back and monitoring relay
  // ****************************************************************
  logic [SC_W-1:0] status_word;
  logic sc_rvalid_reg;
  logic [SC_W-1:0] sc_rdata_reg;
  logic mon_valid_reg;
  logic [SC_W-1:0] mon_data_reg;

  // Module-wide status gathered in one word
  always_comb begin
    status_word = '0;
    status_word[ST_BUSY] = busy_reg; // [RULE12]
    status_word[ST_MISMATCH] = mismatch_reg; // [RULE12]
    status_word[ST_LOST] = lost_reg;
  end

  // Reads answer one cycle later from the addressed unit, or with the status word for SC_STATUS
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      sc_rvalid_reg <= 1'b0;
      sc_rdata_reg <= '0;
    end else begin
      sc_rvalid_reg <= cmd_rd;
      if (cmd_rd) begin
        sc_rdata_reg <= (SC_CMD.addr == SC_STATUS) ? status_word : unit_rd[SC_CMD.unit]; // [RULE13]
      end
    end
  end
  assign SC_RVALID = sc_rvalid_reg;
  assign SC_RDATA = sc_rdata_reg;

  // Sensor data pass to the hub unchanged, registered one cycle later
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      mon_valid_reg <= 1'b0;
      mon_data_reg <= '0;
    end else begin
      mon_valid_reg <= MON_VALID; // [RULE18]
      if (MON_VALID) mon_data_reg <= MON_DATA;
    end
  end
  assign HUB_MON_VALID = mon_valid_reg;
  assign HUB_MON_DATA = mon_data_reg;
endmodule : ctor_readout

// file: hdl/ctor_pkg.sv
// Shared constants and carrier types for the trigger object read-out block
package ctor_pkg;
  localparam int NUM_UNITS = 4;
  localparam int NUM_LANES = 58;
  localparam int LANE_W = 16;
  localparam int NUM_TOPO = 6;
  localparam int ENERGY_W = 12;
  localparam int BCID_W = 12;
  localparam int POS_W = 6;
  localparam int SC_W = 16;
  localparam int TAU_BIT = 15;
  localparam int RING_AW = 3;
  localparam int RING_D = 1 << RING_AW;
  localparam int FIFO_DEPTH = 32;
  localparam int L1_LATENCY = 4;
  // Loopback latency, rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOOP_NS = 25;
  localparam int LOOP_CYC = (LOOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAYLOAD_W = 120;
  localparam int CHECK_W = 8;
  // Slow-control parameter addresses
  localparam logic [1:0] SC_CORE_LO = 2'h0;
  localparam logic [1:0] SC_CORE_HI = 2'h1;
  localparam logic [1:0] SC_THRESH = 2'h2;
  localparam logic [1:0] SC_STATUS = 2'h3;
  // Reset values of unit parameters
  localparam logic [POS_W-1:0] CORE_LO_RST = 6'h00;
  localparam logic [POS_W-1:0] CORE_HI_RST = 6'h39;
  localparam logic [ENERGY_W-1:0] THRESH_RST = 12'h010;
  // Status word bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_MISMATCH = 1;
  localparam int ST_LOST = 2;

  typedef struct packed {
    logic is_tau;
    logic [ENERGY_W-1:0] energy;
    logic [POS_W-1:0] eta;
    logic [1:0] phi;
  } ctor_rec_t;

  typedef struct packed {
    logic [BCID_W-1:0] bcid;
    logic rec_valid;
    ctor_rec_t rec;
    logic [LANE_W-1:0] raw;
  } ctor_unit_pkt_t;

  typedef struct packed {
    logic mismatch;
    ctor_unit_pkt_t [NUM_UNITS-1:0] units;
  } ctor_event_t;

  typedef struct packed {
    logic [PAYLOAD_W-1:0] payload;
    logic [CHECK_W-1:0] check;
  } ctor_frame_t;

  typedef struct packed {
    logic write;
    logic [1:0] unit;
    logic [1:0] addr;
    logic [SC_W-1:0] wdata;
  } ctor_sc_cmd_t;
endpackage : ctor_pkg

// file: hdl/ctor_fifo.sv
// Derandomising FIFO with registered read data
`timescale 1ns/1ps
module ctor_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  logic out_valid_reg;
  logic [W-1:0] out_data_reg;
  wire push = in_valid && in_ready;
  // Head moves into the output register whenever that register is free
  wire load = (cnt_reg != '0) && (!out_valid_reg || out_ready);

  assign in_ready = (cnt_reg != CW'(DEPTH));
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  // Storage array, kept free of reset so it maps to RAM
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  // Pointers, fill count and output stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + AW'(1);
      if (load) begin
        rd_reg <= rd_reg + AW'(1);
        out_data_reg <= mem[rd_reg];
      end
      out_valid_reg <= load || (out_valid_reg && !out_ready);
      cnt_reg <= cnt_reg + CW'(push) - CW'(load);
    end
  end
endmodule : ctor_fifo

// file: sim/ctor_readout_monitor.sv
// Port checker for the trigger object read-out block
`timescale 1ns/1ps
module ctor_readout_monitor (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // Lanes and loopback
  input wire logic [ctor_pkg::NUM_UNITS-1:0][ctor_pkg::NUM_LANES-1:0][ctor_pkg::LANE_W-1:0] LANE_DATA,
  input wire logic [ctor_pkg::NUM_UNITS-1:0][ctor_pkg::LANE_W-1:0] SERDES_LOOP_TX,
  // Control inputs
  input wire logic LEVEL1_ACCEPT,
  input wire logic SC_VALID,
  input wire ctor_pkg::ctor_sc_cmd_t SC_CMD,
  input wire logic CFG_VALID,
  input wire logic HUB_READY,
  input wire logic MON_VALID,
  input wire logic [ctor_pkg::SC_W-1:0] MON_DATA,
  // Watched outputs
  input wire logic SC_RVALID,
  input wire ctor_pkg::ctor_frame_t [ctor_pkg::NUM_TOPO-1:0] TOPO_FRAME,
  input wire logic HUB_VALID,
  input wire ctor_pkg::ctor_event_t HUB_EVENT,
  input wire logic RO_BUSY,
  input wire logic HUB_MON_VALID,
  input wire logic [ctor_pkg::SC_W-1:0] HUB_MON_DATA
);
  import ctor_pkg::*;
  // Backlog of a full buffer plus hub stalls bounds the wait for an event
  localparam int DRAIN_MAX = 1000;
  logic [2:0] up_reg;
  logic rd_req;
  // A read that the loader does not override
  assign rd_req = SC_VALID & ~SC_CMD.write & ~CFG_VALID;
  // Edges since reset release; keeps delay checks off stages filled in reset
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      up_reg <= 3'h0;
    end else if (up_reg != 3'h7) begin
      up_reg <= up_reg + 3'h1;
    end
  end
  // Byte-wise parity of a frame payload
  function automatic logic [CHECK_W-1:0] fold(input logic [PAYLOAD_W-1:0] p);
    logic [CHECK_W-1:0] x;
    x = 8'h00;
    for (int i = 0; i < PAYLOAD_W / 8; i++) begin
      x = x ^ p[8*i +: 8];
    end
    return x;
  endfunction : fold
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  // ****************
  // Assertions
  // ****************
  loop_delay_a: assert property (
    up_reg > 3'h3 |-> SERDES_LOOP_TX[1] == $past(LANE_DATA[1][0], 3))
    else $error("loopback word is not the lane word of three cycles back");
  topo_copies_a: assert property (
    TOPO_FRAME == {NUM_TOPO{TOPO_FRAME[0]}})
    else $error("output frame copies differ");
  frame_check_a: assert property (
    TOPO_FRAME[0].check == fold(TOPO_FRAME[0].payload))
    else $error("frame check byte wrong");
  read_answer_a: assert property (
    rd_req |=> SC_RVALID)
    else $error("read got no answer");
  answer_cause_a: assert property (
    SC_RVALID |-> $past(rd_req))
    else $error("read answer without a read");
  event_hold_a: assert property (
    HUB_VALID && !HUB_READY |=> HUB_VALID && $stable(HUB_EVENT))
    else $error("event dropped or changed while hub stalls");
  accept_event_a: assert property (
    LEVEL1_ACCEPT |-> ##[1:DRAIN_MAX] HUB_VALID)
    else $error("no event offered after accept");
  mon_pass_a: assert property (
    MON_VALID |=> HUB_MON_VALID && HUB_MON_DATA == $past(MON_DATA))
    else $error("monitoring word not passed on");
  mon_quiet_a: assert property (
    !MON_VALID |=> !HUB_MON_VALID)
    else $error("monitoring word without input");
  bunch_flag_a: assert property (
    HUB_VALID |-> HUB_EVENT.mismatch == (HUB_EVENT.units[1].bcid != HUB_EVENT.units[0].bcid
      || HUB_EVENT.units[2].bcid != HUB_EVENT.units[0].bcid
      || HUB_EVENT.units[3].bcid != HUB_EVENT.units[0].bcid))
    else $error("bunch mismatch flag wrong");
  // Main scenarios reached
  cover property (HUB_VALID && HUB_READY);
  cover property (SC_RVALID);
  cover property (RO_BUSY);
endmodule : ctor_readout_monitor

// file: sim/ctor_hub_model.sv
// Hub read-out sink taking merged events at a prompt, slow or stalled pace
`timescale 1ns/1ps
module ctor_hub_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pace: 0 prompt, 1 one take in four cycles, 2 stalled
  input wire logic [1:0] pace,
  // Event stream
  input wire logic hub_valid,
  output logic hub_ready,
  input wire ctor_pkg::ctor_event_t hub_event,
  // Bookkeeping for the bench
  output int take_cnt,
  output ctor_pkg::ctor_event_t last_event
);
  import ctor_pkg::*;
  logic [1:0] cyc_reg;
  initial begin
    hub_ready = 1'b0;
    take_cnt = 0;
    cyc_reg = 2'h0;
  end
  // Ready moves only just after a falling edge, never at the sampling edge
  always @(negedge clk) begin
    hub_ready <= rst_n && (pace == 2'h0 || (pace == 2'h1 && cyc_reg == 2'h0));
  end
  // Each handshake is one event taken
  always @(posedge clk) begin
    cyc_reg <= cyc_reg + 2'h1;
    if (rst_n && hub_valid === 1'b1 && hub_ready) begin
      take_cnt <= take_cnt + 1;
      last_event <= hub_event;
    end
  end
endmodule : ctor_hub_model

// file: sim/tb_calo_trigger_object_readout.sv
// Self-checking bench for the trigger object read-out block
`timescale 1ns/1ps
module tb_calo_trigger_object_readout;
  import ctor_pkg::*;
  logic clk, nrst, bcr, acc, sc_valid, sc_rvalid, cfg_valid, hub_valid, hub_ready;
  logic ro_busy, mon_valid, hub_mon_valid;
  logic [NUM_UNITS-1:0][NUM_LANES-1:0][LANE_W-1:0] lanes;
  logic [NUM_UNITS-1:0][LANE_W-1:0] loop_tx;
  logic [SC_W-1:0] sc_rdata, mon_data, hub_mon_data;
  logic [1:0] pace;
  ctor_sc_cmd_t sc_cmd, cfg_cmd;
  ctor_frame_t [NUM_TOPO-1:0] topo;
  ctor_event_t hub_event, last_ev;
  int take_cnt, failures, comparisons;
  ctor_readout #(.L1_LAT(L1_LATENCY), .FIFO_D(FIFO_DEPTH)) i_dut (.CORE_CLK(clk), .NRST(nrst),
    .LANE_DATA(lanes), .SERDES_LOOP_TX(loop_tx), .BUNCH_RESET(bcr), .LEVEL1_ACCEPT(acc),
    .SC_VALID(sc_valid), .SC_CMD(sc_cmd), .SC_RVALID(sc_rvalid), .SC_RDATA(sc_rdata),
    .CFG_VALID(cfg_valid), .CFG_CMD(cfg_cmd), .TOPO_FRAME(topo), .HUB_VALID(hub_valid),
    .HUB_READY(hub_ready), .HUB_EVENT(hub_event), .RO_BUSY(ro_busy), .MON_VALID(mon_valid),
    .MON_DATA(mon_data), .HUB_MON_VALID(hub_mon_valid), .HUB_MON_DATA(hub_mon_data));
  ctor_hub_model i_hub (.clk(clk), .rst_n(nrst), .pace(pace), .hub_valid(hub_valid),
    .hub_ready(hub_ready), .hub_event(hub_event), .take_cnt(take_cnt), .last_event(last_ev));
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One slow-control request, a one-cycle pulse
  task automatic sc_do(input logic wr, input logic [1:0] u, a, input logic [15:0] d);
    @(negedge clk);
    sc_valid = 1'b1;
    sc_cmd = '{write: wr, unit: u, addr: a, wdata: d};
    @(negedge clk);
    sc_valid = 1'b0;
  endtask : sc_do
  task automatic sc_rd(input logic [1:0] u, a, output logic [15:0] d);
    sc_do(1'b0, u, a, 16'h0000);
    chk("read answer", sc_rvalid, 1'b1);
    d = sc_rdata;
  endtask : sc_rd
  task automatic wait_take(input int n);
    for (int i = 0; i < 100 && take_cnt < n; i++) @(negedge clk);
    chk("events taken", take_cnt, n);
  endtask : wait_take
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  // ****************
  // Scenarios
  // ****************
  task automatic t_params;
    logic [15:0] d;
    for (int u = 0; u < NUM_UNITS; u++) begin
      sc_rd(u[1:0], SC_CORE_LO, d);
      chk("core_lo rst", d, CORE_LO_RST);
      sc_rd(u[1:0], SC_CORE_HI, d);
      chk("core_hi rst", d, CORE_HI_RST);
      sc_rd(u[1:0], SC_THRESH, d);
      chk("thresh rst", d, THRESH_RST);
    end
    sc_do(1'b1, 2'h2, SC_THRESH, 16'h0123);
    sc_rd(2'h2, SC_THRESH, d);
    chk("thresh u2", d, 16'h0123);
    sc_rd(2'h1, SC_THRESH, d);
    chk("thresh u1", d, THRESH_RST);
    // Loader and bus in one cycle: the loader wins even with its write bit low
    @(negedge clk);
    cfg_valid = 1'b1;
    cfg_cmd = '{write: 1'b0, unit: 2'h0, addr: SC_THRESH, wdata: 16'h0055};
    sc_valid = 1'b1;
    sc_cmd = '{write: 1'b0, unit: 2'h0, addr: SC_THRESH, wdata: 16'h0000};
    @(negedge clk);
    cfg_valid = 1'b0;
    sc_valid = 1'b0;
    chk("read under loader", sc_rvalid, 1'b0);
    sc_rd(2'h0, SC_THRESH, d);
    chk("loader write", d, 16'h0055);
    sc_do(1'b1, 2'h0, SC_THRESH, THRESH_RST);
    sc_do(1'b1, 2'h2, SC_THRESH, THRESH_RST);
    sc_do(1'b1, 2'h0, SC_CORE_HI, 16'h0002);
  endtask : t_params
  task automatic t_realtime;
    logic [21:0] exp [3];
    logic [7:0] x;
    lanes[0][3] = 16'h0200;
    lanes[0][1] = 16'h0050;
    lanes[1][0] = 16'h0007;
    lanes[1][5] = 16'h8123;
    lanes[2][57] = 16'h0011;
    lanes[3][9] = 16'h0010;
    exp[0] = {1'b1, 1'b0, 12'h050, 6'h01, 2'h0};
    exp[1] = {1'b1, 1'b1, 12'h123, 6'h05, 2'h1};
    exp[2] = {1'b1, 1'b0, 12'h011, 6'h39, 2'h2};
    repeat (4) @(negedge clk);
    for (int j = 0; j < NUM_TOPO; j++) begin
      for (int k = 0; k < 3; k++) begin
        chk("unit record", topo[j].payload[22*k +: 22], exp[k]);
      end
      chk("below thresh", topo[j].payload[87], 1'b0);
      chk("spare bits", topo[j].payload[119:88], 32'h00000000);
    end
    x = 8'h00;
    for (int i = 0; i < 15; i++) x = x ^ topo[0].payload[8*i +: 8];
    chk("check byte", topo[0].check, x);
  endtask : t_realtime
  task automatic t_readout;
    int n;
    logic [BCID_W-1:0] b;
    n = take_cnt;
    pace = 2'h1;
    @(negedge clk);
    bcr = 1'b1;
    @(negedge clk);
    bcr = 1'b0;
    repeat (12) @(negedge clk);
    acc = 1'b1;
    repeat (2) @(negedge clk);
    acc = 1'b0;
    wait_take(n + 1);
    b = last_ev.units[0].bcid;
    for (int k = 1; k < NUM_UNITS; k++) begin
      chk("unit bunch", last_ev.units[k].bcid, b);
    end
    chk("mismatch", last_ev.mismatch, 1'b0);
    chk("copied energy", last_ev.units[1].rec.energy, 12'h123);
    chk("copied type", last_ev.units[1].rec.is_tau, 1'b1);
    wait_take(n + 2);
    chk("next bunch", last_ev.units[2].bcid, b + 12'h001);
    repeat (20) @(negedge clk);
    chk("one per event", take_cnt, n + 2);
  endtask : t_readout
  task automatic t_fill;
    int n;
    logic busy_seen;
    logic [15:0] d;
    n = take_cnt;
    pace = 2'h2;
    busy_seen = 1'b0;
    for (int i = 0; i < FIFO_DEPTH + 8; i++) begin
      @(negedge clk);
      acc = 1'b1;
      @(negedge clk);
      acc = 1'b0;
      busy_seen = busy_seen | (ro_busy === 1'b1);
    end
    chk("busy seen", busy_seen, 1'b1);
    sc_rd(2'h0, SC_STATUS, d);
    chk("lost flag", d[ST_LOST], 1'b1);
    pace = 2'h0;
    repeat (80) @(negedge clk);
    chk("buffered", take_cnt - n >= FIFO_DEPTH && take_cnt - n <= FIFO_DEPTH + 2, 1'b1);
    sc_do(1'b1, 2'h0, SC_STATUS, 16'h0000);
    sc_rd(2'h0, SC_STATUS, d);
    chk("lost cleared", d[ST_LOST], 1'b0);
  endtask : t_fill
  task automatic t_mon;
    @(negedge clk);
    mon_valid = 1'b1;
    mon_data = 16'hA5C3;
    @(negedge clk);
    mon_valid = 1'b0;
    chk("mon valid", hub_mon_valid, 1'b1);
    chk("mon data", hub_mon_data, 16'hA5C3);
  endtask : t_mon
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    {nrst, bcr, acc, sc_valid, cfg_valid, mon_valid} = 6'h00;
    {lanes, sc_cmd, cfg_cmd, mon_data, pace} = '0;
    failures = 0;
    comparisons = 0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    t_params();
    $display("test params done");
    t_realtime();
    $display("test realtime done");
    t_readout();
    $display("test readout done");
    t_fill();
    $display("test fill done");
    t_mon();
    $display("test monitor done");
    report_and_stop();
  end
endmodule : tb_calo_trigger_object_readout
bind ctor_readout ctor_readout_monitor i_mon (.CORE_CLK(CORE_CLK), .NRST(NRST),
  .LANE_DATA(LANE_DATA), .SERDES_LOOP_TX(SERDES_LOOP_TX), .LEVEL1_ACCEPT(LEVEL1_ACCEPT),
  .SC_VALID(SC_VALID), .SC_CMD(SC_CMD), .CFG_VALID(CFG_VALID), .HUB_READY(HUB_READY),
  .MON_VALID(MON_VALID), .MON_DATA(MON_DATA), .SC_RVALID(SC_RVALID), .TOPO_FRAME(TOPO_FRAME),
  .HUB_VALID(HUB_VALID), .HUB_EVENT(HUB_EVENT), .RO_BUSY(RO_BUSY),
  .HUB_MON_VALID(HUB_MON_VALID), .HUB_MON_DATA(HUB_MON_DATA));
